/* rtl/lbc_regs.sv */
// brightness and output-current register bank of an LED current-sink driver
// assumes a serial host decoder that hands over single byte accesses synchronous to clk_sys
// What this block does
// - The host writes the high byte first and the combined value takes effect on the low byte.
// - In display mode the 16-bit main brightness drives every output.
// - In cluster mode the main brightness drives output 1 only, as its 13 most significant bits.
// - The 12-bit main current sits in 0x02 bits 3:0 and 0x03 and updates on the low-byte write.
// - Output 2 brightness is 13 bits, upper five in 0x04 bits 4:0 and lower eight in 0x05.
// - Reset clears the brightness registers 0x00, 0x01, 0x04 and 0x05.
// - At start-up the current registers load from the two non-volatile configuration bytes.
// - Full scale of the current register means the maximum sink current picked by the scale code.
// - Scale codes 0 to 7 mean 25, 30, 50, 60, 80, 100, 120 and 150 mA.
`timescale 1ns/1ps
`default_nettype none
`include "lbc_map.svh"

module lbc_regs #(
    parameter int MAIN_W = 16,
    parameter int CLU_W = 13,
    parameter int CUR_W = 12
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire lbc_pkg::lbc_req_t host_req,
    input wire logic display_mode,
    input wire logic [2:0] max_sink_current_select,
    input wire logic [7:0] nv_config_byte_zero,
    input wire logic [7:0] nv_config_byte_one,
    output logic [7:0] host_rdata,
    output logic host_rvalid,
    output logic bank_ready,
    output logic [MAIN_W-1:0] out1_brightness,
    output logic [MAIN_W-1:0] out2_brightness,
    output logic [CUR_W-1:0] out_current,
    output logic [7:0] out_max_ma
);

    if (MAIN_W != 16 || CLU_W < 9 || CLU_W > MAIN_W || CUR_W < 9 || CUR_W > 16)
    begin : g_chk
        $error("lbc_regs: unsupported width parameters");
    end

    function automatic logic hit(input lbc_pkg::lbc_req_t r, input logic [7:0] ofs);
        hit = r.addr == ofs;
    endfunction

    lbc_pkg::lbc_state_t state_r;
    logic run;
    logic wr_ok;
    logic rd_ok;
    logic load_nv;
    logic [7:0] brt_main_hi;
    logic [7:0] cur_main_hi;
    logic [7:0] brt_sec_hi;
    logic [MAIN_W-1:0] main_brightness_value;
    logic [CUR_W-1:0] main_current_value;
    logic [CLU_W-1:0] second_output_brightness;
    logic [CUR_W-1:0] nv_current;
    logic [7:0] dec_ma;
    logic [7:0] rdata_r;
    logic rvalid_r;
    logic ready_r;
    logic [MAIN_W-1:0] out1_r;
    logic [MAIN_W-1:0] out2_r;
    logic [CUR_W-1:0] cur_r;
    logic [7:0] max_ma_r;

    assign run = state_r == lbc_pkg::LBC_ST_RUN;
    assign wr_ok = run && host_req.wr;
    assign rd_ok = run && host_req.rd;
    assign load_nv = state_r == lbc_pkg::LBC_ST_LOAD;
    assign nv_current = {nv_config_byte_zero[`LBC_NV0_CUR_LSB +: CUR_W-8], nv_config_byte_one};

    // one load cycle after reset release, then normal access
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= lbc_pkg::LBC_ST_LOAD;
        end else begin
            unique case (state_r)
                lbc_pkg::LBC_ST_LOAD: state_r <= lbc_pkg::LBC_ST_RUN;
                lbc_pkg::LBC_ST_RUN: state_r <= lbc_pkg::LBC_ST_RUN;
                default: state_r <= lbc_pkg::LBC_ST_LOAD;
            endcase
        end
    end

    lbc_pair_reg #(.HI_W(MAIN_W-8)) u_brt_main (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wr_hi(wr_ok && hit(host_req, `LBC_OFS_BRT_MAIN_HI)),
        .wr_lo(wr_ok && hit(host_req, `LBC_OFS_BRT_MAIN_LO)),
        .wdata(host_req.wdata),
        .load(1'b0),
        .load_val('0),
        .hi_shadow(brt_main_hi),
        .value(main_brightness_value)
    );

    // current pair, loaded from nv bytes at start-up
    lbc_pair_reg #(.HI_W(CUR_W-8)) u_cur_main (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wr_hi(wr_ok && hit(host_req, `LBC_OFS_CUR_MAIN_HI)),
        .wr_lo(wr_ok && hit(host_req, `LBC_OFS_CUR_MAIN_LO)),
        .wdata(host_req.wdata),
        .load(load_nv),
        .load_val(nv_current),
        .hi_shadow(cur_main_hi),
        .value(main_current_value)
    );

    lbc_pair_reg #(.HI_W(CLU_W-8)) u_brt_sec (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wr_hi(wr_ok && hit(host_req, `LBC_OFS_BRT_SEC_HI)),
        .wr_lo(wr_ok && hit(host_req, `LBC_OFS_BRT_SEC_LO)),
        .wdata(host_req.wdata),
        .load(1'b0),
        .load_val('0),
        .hi_shadow(brt_sec_hi),
        .value(second_output_brightness)
    );

    lbc_scale_dec u_dec (
        .code(max_sink_current_select),
        .max_ma(dec_ma)
    );

    // read answer one cycle after the request
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= `LBC_RST_BYTE;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= rd_ok;
            if (rd_ok) begin
                unique case (host_req.addr)
                    `LBC_OFS_BRT_MAIN_HI: rdata_r <= brt_main_hi;
                    `LBC_OFS_BRT_MAIN_LO: rdata_r <= main_brightness_value[7:0];
                    `LBC_OFS_CUR_MAIN_HI: rdata_r <= cur_main_hi;
                    `LBC_OFS_CUR_MAIN_LO: rdata_r <= main_current_value[7:0];
                    `LBC_OFS_BRT_SEC_HI: rdata_r <= brt_sec_hi;
                    `LBC_OFS_BRT_SEC_LO: rdata_r <= second_output_brightness[7:0];
                    default: rdata_r <= `LBC_RD_UNMAPPED;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            out1_r <= '0;
            out2_r <= '0;
        end else if (display_mode) begin
            out1_r <= main_brightness_value;
            out2_r <= main_brightness_value;
        end else begin
            out1_r <= MAIN_W'(main_brightness_value[MAIN_W-1 -: CLU_W]);
            out2_r <= MAIN_W'(second_output_brightness);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cur_r <= '0;
            max_ma_r <= `LBC_RST_BYTE;
            ready_r <= 1'b0;
        end else begin
            cur_r <= main_current_value;
            max_ma_r <= dec_ma;
            ready_r <= run;
        end
    end

    assign host_rdata = rdata_r;
    assign host_rvalid = rvalid_r;
    assign bank_ready = ready_r;
    assign out1_brightness = out1_r;
    assign out2_brightness = out2_r;
    assign out_current = cur_r;
    assign out_max_ma = max_ma_r;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    logic wr_bhi;
    logic wr_blo;
    assign wr_bhi = wr_ok && hit(host_req, `LBC_OFS_BRT_MAIN_HI);
    assign wr_blo = wr_ok && hit(host_req, `LBC_OFS_BRT_MAIN_LO);

    property p_lo_commit;
        wr_bhi ##1 wr_blo |=> main_brightness_value == {$past(host_req.wdata, 2),
            $past(host_req.wdata)};
    endproperty
    a_lo_commit: assert property (p_lo_commit) else $error("low byte did not commit");

    property p_hi_hold;
        wr_bhi |=> $stable(main_brightness_value);
    endproperty
    a_hi_hold: assert property (p_hi_hold) else $error("high byte leaked early");

    property p_disp;
        display_mode ##1 display_mode |-> out1_brightness == $past(main_brightness_value)
            && out2_brightness == out1_brightness;
    endproperty
    a_disp: assert property (p_disp) else $error("display brightness wrong");

    property p_clu;
        !display_mode |=> out1_brightness == {3'h0, $past(main_brightness_value[15:3])};
    endproperty
    a_clu: assert property (p_clu) else $error("cluster 1 brightness wrong");

    property p_cur;
        wr_ok && hit(host_req, `LBC_OFS_CUR_MAIN_LO) |=> ##1
            out_current[7:0] == $past(host_req.wdata, 2);
    endproperty
    a_cur: assert property (p_cur) else $error("current not updated");

    property p_sec;
        wr_ok && hit(host_req, `LBC_OFS_BRT_SEC_HI) |=>
            brt_sec_hi == {3'h0, $past(host_req.wdata[4:0])};
    endproperty
    a_sec: assert property (p_sec) else $error("output 2 high byte wrong");

    property p_rst_zero;
        load_nv |-> main_brightness_value == '0 && second_output_brightness == '0;
    endproperty
    a_rst_zero: assert property (p_rst_zero) else $error("brightness not cleared");

    property p_nv_load;
        load_nv |=> main_current_value == $past(nv_current);
    endproperty
    a_nv_load: assert property (p_nv_load) else $error("nv current not loaded");

    property p_scale;
        $stable(max_sink_current_select) && max_sink_current_select == 3'h7
            |=> out_max_ma == 8'h96;
    endproperty
    a_scale: assert property (p_scale) else $error("full scale wrong");

    property p_scale_lo;
        max_sink_current_select == 3'h0 |=> out_max_ma == 8'h19;
    endproperty
    a_scale_lo: assert property (p_scale_lo) else $error("scale code 0 wrong");

    property p_resv;
        rd_ok && hit(host_req, `LBC_OFS_CUR_MAIN_HI) |=> host_rvalid && host_rdata[7:4] == 4'h0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bits not zero");

    property p_resv_sec;
        rd_ok && hit(host_req, `LBC_OFS_BRT_SEC_HI) |=>
            host_rvalid && host_rdata[7:5] == 3'h0;
    endproperty
    a_resv_sec: assert property (p_resv_sec) else $error("0x04 reserved bits set");

    property p_hi_shadow;
        wr_bhi |=> brt_main_hi == $past(host_req.wdata);
    endproperty
    a_hi_shadow: assert property (p_hi_shadow) else $error("shadow missed byte");

    property p_rd_hi;
        rd_ok && hit(host_req, `LBC_OFS_BRT_MAIN_HI) |=>
            host_rvalid && host_rdata == $past(brt_main_hi);
    endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("high read not from shadow");

    property p_cur_hold;
        wr_ok && hit(host_req, `LBC_OFS_CUR_MAIN_HI) |=> $stable(main_current_value);
    endproperty
    a_cur_hold: assert property (p_cur_hold) else $error("current moved on high byte");

    property p_sec_commit;
        wr_ok && hit(host_req, `LBC_OFS_BRT_SEC_LO) |=>
            second_output_brightness == {$past(brt_sec_hi[4:0]), $past(host_req.wdata)};
    endproperty
    a_sec_commit: assert property (p_sec_commit) else $error("output 2 not loaded");

    property p_scale_mid;
        max_sink_current_select == 3'h4 |=> out_max_ma == 8'h50;
    endproperty
    a_scale_mid: assert property (p_scale_mid) else $error("scale code 4 wrong");

    c_split: cover property (wr_bhi ##[1:4] wr_blo);
    c_cluster: cover property (!display_mode && wr_blo);
    c_read: cover property (rd_ok ##1 host_rvalid);
    c_mode_flip: cover property (display_mode ##1 !display_mode);

endmodule

`default_nettype wire

/* rtl/lbc_map.svh */
// register offsets, reset values and current-scale table for the brightness/current bank
// assumes an 8-bit register address and 8-bit data path from the serial host decoder
`ifndef LBC_MAP_SVH
`define LBC_MAP_SVH

`define LBC_OFS_BRT_MAIN_HI 8'h00
`define LBC_OFS_BRT_MAIN_LO 8'h01
`define LBC_OFS_CUR_MAIN_HI 8'h02
`define LBC_OFS_CUR_MAIN_LO 8'h03
`define LBC_OFS_BRT_SEC_HI 8'h04
`define LBC_OFS_BRT_SEC_LO 8'h05

`define LBC_RST_BYTE 8'h00
`define LBC_RD_UNMAPPED 8'h00

// nv byte zero carries current bits 11:8 in its low nibble
`define LBC_NV0_CUR_LSB 0

// maximum sink current in mA per scale code
`define LBC_MA_CODE0 8'h19
`define LBC_MA_CODE1 8'h1E
`define LBC_MA_CODE2 8'h32
`define LBC_MA_CODE3 8'h3C
`define LBC_MA_CODE4 8'h50
`define LBC_MA_CODE5 8'h64
`define LBC_MA_CODE6 8'h78
`define LBC_MA_CODE7 8'h96

`endif

/* rtl/lbc_pkg.sv */
// types shared by the brightness/current register bank
// assumes nothing beyond the map header for numbers
package lbc_pkg;

    typedef enum logic [1:0] {
        LBC_ST_LOAD = 2'b01,
        LBC_ST_RUN = 2'b10
    } lbc_state_t;

    // one register access from the serial host decoder
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lbc_req_t;

endpackage

/* rtl/lbc_pair_reg.sv */
// split register pair: high byte held in a shadow, whole value committed on the low byte
// assumes write strobes are one cycle wide and already address-decoded
`timescale 1ns/1ps
`default_nettype none

module lbc_pair_reg #(
    parameter int HI_W = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wr_hi,
    input wire logic wr_lo,
    input wire logic [7:0] wdata,
    input wire logic load,
    input wire logic [HI_W+7:0] load_val,
    output logic [7:0] hi_shadow,
    output logic [HI_W+7:0] value
);

    logic [HI_W-1:0] shadow_r;
    logic [HI_W+7:0] value_r;

    if (HI_W < 1 || HI_W > 8) begin : g_chk
        $error("lbc_pair_reg: HI_W must be 1 to 8");
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            shadow_r <= '0;
        end else if (load) begin
            shadow_r <= load_val[HI_W+7:8];
        end else if (wr_hi) begin
            shadow_r <= wdata[HI_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            value_r <= '0;
        end else if (load) begin
            value_r <= load_val;
        end else if (wr_lo) begin
            value_r <= {shadow_r, wdata};
        end
    end

    assign hi_shadow = 8'({shadow_r});
    assign value = value_r;

endmodule

`default_nettype wire

/* rtl/lbc_scale_dec.sv */
// decodes the 3-bit current-scale code into a full-scale sink current in mA
// assumes the code is a stable configuration level
`timescale 1ns/1ps
`default_nettype none
`include "lbc_map.svh"

module lbc_scale_dec (
    input wire logic [2:0] code,
    output logic [7:0] max_ma
);

    always_comb begin
        unique case (code)
            3'h0: max_ma = `LBC_MA_CODE0;
            3'h1: max_ma = `LBC_MA_CODE1;
            3'h2: max_ma = `LBC_MA_CODE2;
            3'h3: max_ma = `LBC_MA_CODE3;
            3'h4: max_ma = `LBC_MA_CODE4;
            3'h5: max_ma = `LBC_MA_CODE5;
            3'h6: max_ma = `LBC_MA_CODE6;
            3'h7: max_ma = `LBC_MA_CODE7;
        endcase
    end

endmodule

`default_nettype wire

/* testbench/lbc_host_model.sv */
// host side model: hands single byte accesses to the register bank
// assumes requests launch on falling edges of clk_sys and stand for one rising edge
`timescale 1ns/1ps
`default_nettype none

module lbc_host_model (
    input wire logic clk_sys,
    input wire logic host_rvalid,
    input wire logic [7:0] host_rdata,
    output var lbc_pkg::lbc_req_t host_req
);
    initial host_req = '0;

    task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        host_req.wr = 1'b1;
        host_req.addr = a;
        host_req.wdata = d;
        @(negedge clk_sys);
        host_req.wr = 1'b0;
        host_req.addr = ~a;
        host_req.wdata = ~d;
    endtask

    // high then low on adjacent edges, strobe held between them
    task automatic write_pair(input logic [7:0] a, input logic [7:0] dh, input logic [7:0] dl);
        @(negedge clk_sys);
        host_req.wr = 1'b1;
        host_req.addr = a;
        host_req.wdata = dh;
        @(negedge clk_sys);
        host_req.addr = a + 8'h01;
        host_req.wdata = dl;
        @(negedge clk_sys);
        host_req.wr = 1'b0;
        host_req.addr = ~a;
        host_req.wdata = ~dl;
    endtask

    // answer stands for the cycle after the taking edge; sampled mid-cycle
    task automatic read_byte(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clk_sys);
        host_req.rd = 1'b1;
        host_req.addr = a;
        @(negedge clk_sys);
        v = host_rvalid;
        d = host_rdata;
        host_req.rd = 1'b0;
        host_req.addr = ~a;
    endtask
endmodule

`default_nettype wire

/* testbench/test_led_brightness_current_regs.sv */
// self-checking bench for the brightness/current register bank
// assumes the host model drives the register port; integer model predicts every result
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %0h got %0h", n, e, g); end end

module test_led_brightness_current_regs;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    lbc_pkg::lbc_req_t host_req;
    logic display_mode = 1'b1;
    logic [2:0] sel = 3'h0;
    logic [7:0] nv0 = 8'h00;
    logic [7:0] nv1 = 8'h00;
    logic [7:0] rdata;
    logic rvalid;
    logic bank_ready;
    logic [15:0] o1;
    logic [15:0] o2;
    logic [11:0] cur;
    logic [7:0] ma;
    int error_cnt = 0;
    int checks_done = 0;
    int seed;
    int sh[3];
    int act[3];
    int hmask[3] = '{8'hFF, 8'h0F, 8'h1F};
    int ma_tab[8] = '{25, 30, 50, 60, 80, 100, 120, 150};

    always #10 clk_sys = ~clk_sys;

    lbc_regs dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .host_req(host_req),
        .display_mode(display_mode), .max_sink_current_select(sel),
        .nv_config_byte_zero(nv0), .nv_config_byte_one(nv1),
        .host_rdata(rdata), .host_rvalid(rvalid), .bank_ready(bank_ready),
        .out1_brightness(o1), .out2_brightness(o2), .out_current(cur), .out_max_ma(ma)
    );

    lbc_host_model host (
        .clk_sys(clk_sys), .host_rvalid(rvalid), .host_rdata(rdata), .host_req(host_req)
    );

    task automatic results();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check_outs();
        repeat (4) @(negedge clk_sys);
        `CHK("out1", display_mode ? act[0] : act[0] >> 3, o1)
        `CHK("out2", display_mode ? act[0] : act[2], o2)
        `CHK("current", act[1], cur)
        `CHK("max_ma", ma_tab[sel], ma)
    endtask

    task automatic rd(input logic [7:0] a);
        logic [7:0] d;
        logic v;
        int e;
        host.read_byte(a, d, v);
        e = (a > 8'h05) ? 0 : (a[0] ? act[a >> 1] & 8'hFF : sh[a >> 1]);
        `CHK("rvalid", 1'b1, v)
        `CHK("rdata", e, d)
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.write_byte(a, d);
        if (a <= 8'h05 && !a[0]) sh[a >> 1] = d & hmask[a >> 1];
        if (a <= 8'h05 && a[0]) act[a >> 1] = (sh[a >> 1] << 8) | d;
        check_outs();
    endtask

    task automatic wr_pair(input logic [7:0] a, input logic [7:0] dh, input logic [7:0] dl);
        host.write_pair(a, dh, dl);
        sh[a >> 1] = dh & hmask[a >> 1];
        act[a >> 1] = (sh[a >> 1] << 8) | dl;
        check_outs();
    endtask

    task automatic do_reset();
        rst_n = 1'b0;
        // upper nibble of byte zero is not the bank's and is left random
        nv0 = $random(seed);
        nv1 = $random(seed);
        repeat (16) @(negedge clk_sys);
        rst_n = 1'b1;
        sh = '{0, nv0 & 8'h0F, 0};
        act = '{0, ((nv0 & 8'h0F) << 8) | nv1, 0};
        for (int i = 0; i < 10 && bank_ready !== 1'b1; i++) @(negedge clk_sys);
        `CHK("bank_ready", 1'b1, bank_ready)
        check_outs();
        for (int a = 0; a < 6; a++) rd(a);
    endtask

    initial begin
        seed = 76395;
        do_reset();
        for (int k = 0; k < 8; k++) begin
            sel = k;
            check_outs();
        end
        wr(8'h02, 8'hFF);
        wr(8'h04, 8'hFF);
        rd(8'h02);
        rd(8'h04);
        wr(8'h05, 8'hA5);
        wr(8'h03, 8'h00);
        wr_pair(8'h00, 8'h12, 8'h34);
        for (int n = 0; n < 300; n++) begin
            logic [7:0] a;
            a = $random(seed) & 7;
            if (a == 8'h07) a = 8'h80;
            display_mode = $random(seed);
            sel = $random(seed);
            if (n % 16 == 0) wr_pair(8'((n / 16) % 3 * 2), $random(seed), $random(seed));
            if ($random(seed) & 1) wr(a, $random(seed));
            else rd(a);
        end
        do_reset();
        results();
    end

    initial begin
        #(40000 * 20);
        error_cnt++;
        results();
    end
endmodule

`default_nettype wire
